/* core/ics_sequencer.sv */
// Serial bus control bits with master sequencer and addressed slave engine.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module ics_sequencer
  import ics_pkg::*;
#(
  parameter int QUARTER = ICS_QUARTER_CYC
)(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Register port.
  input  wire ics_bus_req_t bus_req,
  output logic [15:0]      bus_rdata,
  // Serial pins, open drain.
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  // Interrupt.
  output logic             irq
);

  ics_ctrl_t   ctrl_reg;
  logic [9:0]  own_addr_reg;
  logic [3:0]  status_reg;
  logic [3:0]  mask_reg;
  logic [7:0]  rx_data_reg;
  logic [7:0]  tx_data_reg;
  logic [15:0] rdata_reg;
  logic [1:0]  sda_sync_reg;
  logic [1:0]  scl_sync_reg;
  logic        sda_prev_reg;
  logic        scl_prev_reg;
  ics_mst_t    mst_state_reg;
  logic [1:0]  mph_reg;
  logic [2:0]  mbit_reg;
  logic [15:0] tick_cnt_reg;
  logic        mst_sda_low_reg;
  logic        mst_scl_low_reg;
  logic [7:0]  mshift_reg;
  ics_slv_t    slv_state_reg;
  logic [3:0]  sbit_reg;
  logic [7:0]  sshift_reg;
  logic        slv_sda_low_reg;
  logic        ten_hi_seen_reg;
  logic        rw_reg;
  logic        ack_next_tx_reg;
  logic        ten_lo_next_reg;
  logic        sda_s, scl_s, bus_start, bus_stop, scl_rise, scl_fall;
  logic        tick, mst_finish, byte_done, addr_done, rx_done, tx_start;
  logic        m_ack, m_gcall, m_ten_hi, slv_active, slv_scl_hold;
  logic [3:0]  evt_set;

  // Pins from outside pass two flip-flops; the edge logic reads the second and a one-cycle delayed copy of it.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sda_sync_reg <= 2'h3;
      scl_sync_reg <= 2'h3;
      sda_prev_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_prev_reg <= sda_sync_reg[1];
      scl_prev_reg <= scl_sync_reg[1];
    end
  end

  // Bus conditions and clock edges.
  assign sda_s     = sda_sync_reg[1];
  assign scl_s     = scl_sync_reg[1];
  assign bus_start = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  assign bus_stop  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
  assign scl_rise  = scl_s && !scl_prev_reg;
  assign scl_fall  = !scl_s && scl_prev_reg;

  // Quarter-bit tick; it waits while another device stretches a released clock.
  assign tick = (mst_state_reg != M_IDLE) && (tick_cnt_reg == 16'(QUARTER - 1));
  always_ff @(posedge clk_sys) begin
    if (reset || mst_state_reg == M_IDLE || tick) begin
      tick_cnt_reg <= 16'h0000;
    end else if (mst_scl_low_reg || scl_s) begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  // Last quarter of each master sequence.
  always_comb begin
    mst_finish = 1'b0;
    if (tick) begin
      unique case (mst_state_reg)
        M_IDLE:   mst_finish = 1'b0;
        M_START:  mst_finish = (mph_reg == 2'h1);
        M_STOP:   mst_finish = (mph_reg == 2'h2);
        M_RECV:   mst_finish = (mph_reg == 2'h3) && (mbit_reg == 3'h7);
        M_RSTART,
        M_ACK:    mst_finish = (mph_reg == 2'h3);
      endcase
    end
  end

  // Master sequencer: drives the pins quarter by quarter.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mst_state_reg   <= M_IDLE;
      mph_reg         <= 2'h0;
      mbit_reg        <= 3'h0;
      mst_sda_low_reg <= 1'b0;
      mst_scl_low_reg <= 1'b0;
      mshift_reg      <= ICS_DATA_RST;
    end else if (mst_state_reg == M_IDLE) begin
      mph_reg  <= 2'h0;
      mbit_reg <= 3'h0;
      if (ctrl_reg.start_request) begin
        mst_state_reg <= M_START;
      end else if (ctrl_reg.repeated_start_request) begin
        mst_state_reg <= M_RSTART;
      end else if (ctrl_reg.stop_request) begin
        mst_state_reg <= M_STOP;
      end else if (ctrl_reg.master_receive_request) begin
        mst_state_reg <= M_RECV;
      end else if (ctrl_reg.ack_sequence_request) begin
        mst_state_reg <= M_ACK;
      end
    end else if (tick) begin
      mph_reg <= mph_reg + 2'h1;
      if (mst_finish) begin
        mst_state_reg <= M_IDLE;
      end
      unique case (mst_state_reg)
        M_START: begin
          if (mph_reg == 2'h0) mst_sda_low_reg <= 1'b1;
          else mst_scl_low_reg <= 1'b1;
        end
        M_RSTART: begin
          unique case (mph_reg)
            2'h0: mst_sda_low_reg <= 1'b0;
            2'h1: mst_scl_low_reg <= 1'b0;
            2'h2: mst_sda_low_reg <= 1'b1;
            2'h3: mst_scl_low_reg <= 1'b1;
          endcase
        end
        M_STOP: begin
          if (mph_reg == 2'h0) mst_sda_low_reg <= 1'b1;
          else if (mph_reg == 2'h1) mst_scl_low_reg <= 1'b0;
          else mst_sda_low_reg <= 1'b0;
        end
        M_RECV: begin
          unique case (mph_reg)
            2'h0: mst_sda_low_reg <= 1'b0;
            2'h1: mst_scl_low_reg <= 1'b0;
            2'h2: mshift_reg      <= {mshift_reg[6:0], sda_s};
            2'h3: begin
              mst_scl_low_reg <= 1'b1;
              mbit_reg        <= mbit_reg + 3'h1;
            end
          endcase
        end
        M_ACK: begin
          unique case (mph_reg)
            2'h0: mst_sda_low_reg <= !ctrl_reg.ack_value;
            2'h1: mst_scl_low_reg <= 1'b0;
            2'h2: mst_scl_low_reg <= 1'b1;
            2'h3: mst_sda_low_reg <= 1'b0;
          endcase
        end
        M_IDLE: mph_reg <= 2'h0;
      endcase
    end
  end

  // Address decision for the byte held in the slave shift register.
  ics_addr_match u_match (
    .rx_byte     (sshift_reg),
    .ten_hi_seen (ten_hi_seen_reg),
    .own_addr    (own_addr_reg),
    .ctrl        (ctrl_reg),
    .ack         (m_ack),
    .gcall_hit   (m_gcall),
    .ten_hi_hit  (m_ten_hi)
  );

  // Slave byte boundaries, taken on the falling clock after the eighth bit.
  assign byte_done = scl_fall && (sbit_reg == 4'h8);
  assign addr_done = byte_done && (slv_state_reg == S_ADDR);
  assign rx_done   = byte_done && (slv_state_reg == S_RX);
  assign tx_start  = scl_fall && (slv_state_reg == S_ACK) && ack_next_tx_reg;
  assign slv_active = (slv_state_reg != S_IDLE) && (slv_state_reg != S_ADDR);

  // Slave engine: address phase, acknowledge, receive and transmit.
  always_ff @(posedge clk_sys) begin
    if (reset || bus_stop) begin
      slv_state_reg   <= S_IDLE;
      sbit_reg        <= 4'h0;
      sshift_reg      <= ICS_DATA_RST;
      slv_sda_low_reg <= 1'b0;
      ten_hi_seen_reg <= 1'b0;
      rw_reg          <= 1'b0;
      ack_next_tx_reg <= 1'b0;
      ten_lo_next_reg <= 1'b0;
    end else if (bus_start) begin
      slv_state_reg   <= S_ADDR;
      sbit_reg        <= 4'h0;
      slv_sda_low_reg <= 1'b0;
    end else if (scl_rise && sbit_reg != 4'h8 && (slv_state_reg == S_ADDR || slv_state_reg == S_RX)) begin
      sshift_reg <= {sshift_reg[6:0], sda_s};
      sbit_reg   <= sbit_reg + 4'h1;
    end else if (scl_rise && slv_state_reg == S_TXACK) begin
      slv_state_reg <= sda_s ? S_IDLE : S_TX;
      sbit_reg      <= 4'h0;
    end else if (addr_done) begin
      sbit_reg        <= 4'h0;
      slv_sda_low_reg <= m_ack;
      slv_state_reg   <= m_ack ? S_ACK : S_IDLE;
      // The low byte of a ten-bit address carries no direction bit.
      rw_reg          <= ten_hi_seen_reg ? rw_reg : sshift_reg[0];
      ack_next_tx_reg <= sshift_reg[0] && !m_ten_hi && !ten_hi_seen_reg;
      ten_lo_next_reg <= m_ten_hi;
      if (m_ten_hi) ten_hi_seen_reg <= 1'b1;
    end else if (rx_done) begin
      sbit_reg        <= 4'h0;
      slv_sda_low_reg <= 1'b1;
      slv_state_reg   <= S_ACK;
      ack_next_tx_reg <= 1'b0;
    end else if (scl_fall && slv_state_reg == S_ACK) begin
      if (ack_next_tx_reg) begin
        slv_state_reg   <= S_TX;
        slv_sda_low_reg <= !tx_data_reg[7];
        sshift_reg      <= {tx_data_reg[6:0], 1'b1};
        sbit_reg        <= 4'h1;
      end else if (ten_lo_next_reg && !rw_reg) begin
        slv_state_reg   <= S_ADDR;
        slv_sda_low_reg <= 1'b0;
        ten_lo_next_reg <= 1'b0;
      end else begin
        slv_state_reg   <= S_RX;
        slv_sda_low_reg <= 1'b0;
      end
    end else if (scl_fall && slv_state_reg == S_TX) begin
      if (sbit_reg == 4'h8) begin
        slv_sda_low_reg <= 1'b0;
        slv_state_reg   <= S_TXACK;
      end else begin
        slv_sda_low_reg <= !sshift_reg[7];
        sshift_reg      <= {sshift_reg[6:0], 1'b1};
        sbit_reg        <= sbit_reg + 4'h1;
      end
    end
  end

  // Slave holds the clock low while its release bit is clear.
  assign slv_scl_hold = slv_active && !ctrl_reg.clock_release_control && !scl_s;

  // Open-drain pins: drive low only, enable while pulling.
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe  = mst_sda_low_reg || slv_sda_low_reg;
  assign scl_oe  = mst_scl_low_reg || slv_scl_hold;

  // Control register: software writes, hardware clears finished requests and release.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_reg <= ICS_CTRL_RST;
    end else begin
      if (bus_req.wr && bus_req.addr == ICS_OFS_CTRL) begin
        ctrl_reg        <= ics_ctrl_t'(bus_req.wdata);
        ctrl_reg.unused <= 3'h0;
        if (!ctrl_reg.slave_clock_stretch_enable) begin
          ctrl_reg.clock_release_control <= ctrl_reg.clock_release_control | bus_req.wdata[12];
        end
      end
      if (tx_start || (rx_done && ctrl_reg.slave_clock_stretch_enable)) begin
        ctrl_reg.clock_release_control <= 1'b0;
      end
      if (mst_finish) begin
        unique case (mst_state_reg)
          M_START:  ctrl_reg.start_request          <= 1'b0;
          M_RSTART: ctrl_reg.repeated_start_request <= 1'b0;
          M_STOP:   ctrl_reg.stop_request           <= 1'b0;
          M_RECV:   ctrl_reg.master_receive_request <= 1'b0;
          M_ACK:    ctrl_reg.ack_sequence_request   <= 1'b0;
          M_IDLE:   ctrl_reg.start_request          <= ctrl_reg.start_request;
        endcase
      end
    end
  end

  // Plain storage registers: own address, mask and transmit byte.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      own_addr_reg <= ICS_OWNADR_RST;
      mask_reg     <= ICS_EVT_RST;
      tx_data_reg  <= ICS_DATA_RST;
    end else if (bus_req.wr) begin
      if (bus_req.addr == ICS_OFS_OWNADR) own_addr_reg <= bus_req.wdata[9:0];
      if (bus_req.addr == ICS_OFS_MASK)   mask_reg     <= bus_req.wdata[3:0];
      if (bus_req.addr == ICS_OFS_DATA)   tx_data_reg  <= bus_req.wdata[7:0];
    end
  end

  // Received byte from either the master receive or the slave receive.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_data_reg <= ICS_DATA_RST;
    end else if (mst_finish && mst_state_reg == M_RECV) begin
      rx_data_reg <= mshift_reg;
    end else if (rx_done) begin
      rx_data_reg <= sshift_reg;
    end
  end

  // Sticky events; a new event wins over a write-one clear in the same cycle.
  always_comb begin
    evt_set               = 4'h0;
    evt_set[ICS_EV_MDONE] = mst_finish;
    evt_set[ICS_EV_SADDR] = addr_done && m_ack && !m_gcall;
    evt_set[ICS_EV_GCALL] = addr_done && m_gcall && ctrl_reg.general_call_enable;
    evt_set[ICS_EV_SRX]   = rx_done;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_reg <= ICS_EVT_RST;
    end else if (bus_req.wr && bus_req.addr == ICS_OFS_STATUS) begin
      status_reg <= (status_reg & ~bus_req.wdata[3:0]) | evt_set;
    end else begin
      status_reg <= status_reg | evt_set;
    end
  end

  assign irq = |(status_reg & mask_reg);

  // Read data stand in the cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_reg <= 16'h0000;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        ICS_OFS_CTRL:   rdata_reg <= 16'(ctrl_reg);
        ICS_OFS_OWNADR: rdata_reg <= {6'h00, own_addr_reg};
        ICS_OFS_STATUS: rdata_reg <= {12'h000, status_reg};
        ICS_OFS_MASK:   rdata_reg <= {12'h000, mask_reg};
        ICS_OFS_DATA:   rdata_reg <= {8'h00, rx_data_reg};
        default:        rdata_reg <= 16'h0000;
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  assign bus_rdata = rdata_reg;

  // Checks on the documented behaviour.
  accept_all_ack_a: assert property (@(posedge clk_sys) disable iff (reset)
    (addr_done && ctrl_reg.accept_all_addresses) |=> (slv_state_reg == S_ACK) && sda_oe)
    else $error("accept-all address not acknowledged");

  seven_bit_a: assert property (@(posedge clk_sys) disable iff (reset)
    (addr_done && !ctrl_reg.ten_bit_addr_select && sshift_reg != ICS_GCALL_ADDR
     && sshift_reg[7:1] == own_addr_reg[6:0]) |=> slv_state_reg == S_ACK)
    else $error("seven-bit own address not acknowledged");

  gcall_irq_a: assert property (@(posedge clk_sys) disable iff (reset)
    (addr_done && m_gcall && ctrl_reg.general_call_enable) |=> status_reg[ICS_EV_GCALL])
    else $error("general call event not raised");

  gcall_nack_a: assert property (@(posedge clk_sys) disable iff (reset)
    (addr_done && m_gcall && !ctrl_reg.general_call_enable && !ctrl_reg.accept_all_addresses)
    |=> slv_state_reg == S_IDLE && !status_reg[ICS_EV_GCALL] ##1 !slv_sda_low_reg)
    else $error("general call answered while disabled");

  stretch_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    (slv_active && !ctrl_reg.clock_release_control && !scl_s) |-> scl_oe)
    else $error("slave failed to hold the clock");

  release_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
    (rx_done && ctrl_reg.slave_clock_stretch_enable) |=> !ctrl_reg.clock_release_control)
    else $error("release bit not cleared after slave receive");

  ack_value_a: assert property (@(posedge clk_sys) disable iff (reset)
    (mst_state_reg == M_ACK && mph_reg != 2'h0) |-> mst_sda_low_reg == !ctrl_reg.ack_value)
    else $error("wrong acknowledge value driven");

  ack_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
    (mst_finish && mst_state_reg == M_ACK) |=> !ctrl_reg.ack_sequence_request && !mst_sda_low_reg)
    else $error("acknowledge request not cleared");

  recv_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
    (mst_finish && mst_state_reg == M_RECV) |-> mbit_reg == 3'h7 ##1 !ctrl_reg.master_receive_request)
    else $error("receive request not cleared after eighth bit");

  stop_seq_a: assert property (@(posedge clk_sys) disable iff (reset)
    (mst_finish && mst_state_reg == M_STOP) |=> !ctrl_reg.stop_request && !sda_oe && !mst_scl_low_reg)
    else $error("stop sequence did not end released");

  rstart_seq_a: assert property (@(posedge clk_sys) disable iff (reset)
    (mst_finish && mst_state_reg == M_RSTART) |=> !ctrl_reg.repeated_start_request && mst_scl_low_reg)
    else $error("repeated start not completed");

  start_seq_a: assert property (@(posedge clk_sys) disable iff (reset)
    (mst_finish && mst_state_reg == M_START) |=> !ctrl_reg.start_request && mst_sda_low_reg && mst_scl_low_reg)
    else $error("start sequence not completed");

  start_cov_c: cover property (@(posedge clk_sys) disable iff (reset) mst_finish && mst_state_reg == M_START);
  recv_cov_c: cover property (@(posedge clk_sys) disable iff (reset) mst_finish && mst_state_reg == M_RECV);
  slave_tx_cov_c: cover property (@(posedge clk_sys) disable iff (reset) tx_start);
  gcall_cov_c: cover property (@(posedge clk_sys) disable iff (reset) evt_set[ICS_EV_GCALL]);

endmodule

/* core/ics_pkg.sv */
// Shared constants and types for the serial bus control bit sequencer.
package ics_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] ICS_OFS_CTRL   = 4'h0;
  localparam logic [3:0] ICS_OFS_OWNADR = 4'h4;
  localparam logic [3:0] ICS_OFS_STATUS = 4'h8;
  localparam logic [3:0] ICS_OFS_MASK   = 4'hC;
  localparam logic [3:0] ICS_OFS_DATA   = 4'h0 + 4'hA;

  // Reset values; the clock release bit comes out of reset set.
  localparam logic [15:0] ICS_CTRL_RST   = 16'h1000;
  localparam logic [9:0]  ICS_OWNADR_RST = 10'h000;
  localparam logic [3:0]  ICS_EVT_RST    = 4'h0;
  localparam logic [7:0]  ICS_DATA_RST   = 8'h00;

  // Event bit positions in the status and mask registers.
  localparam int ICS_EV_MDONE = 0;
  localparam int ICS_EV_SADDR = 1;
  localparam int ICS_EV_GCALL = 2;
  localparam int ICS_EV_SRX   = 3;

  // Address patterns seen on the bus.
  localparam logic [7:0] ICS_GCALL_ADDR = 8'h00;
  localparam logic [4:0] ICS_TEN_PREFIX = 5'h1E;

  // Serial clock timing: one bit period split into four quarters.
  localparam int ICS_CLK_PERIOD_NS = 50;
  localparam int ICS_SCL_PERIOD_NS = 10000;
  localparam int ICS_QUARTER_CYC   = (ICS_SCL_PERIOD_NS / 4) / ICS_CLK_PERIOD_NS;

  // Control register layout, bit 15 down to bit 0.
  typedef struct packed {
    logic [2:0] unused;
    logic       clock_release_control;
    logic       accept_all_addresses;
    logic       ten_bit_addr_select;
    logic       slew_limit_disable;
    logic       smbus_threshold_select;
    logic       general_call_enable;
    logic       slave_clock_stretch_enable;
    logic       ack_value;
    logic       ack_sequence_request;
    logic       master_receive_request;
    logic       stop_request;
    logic       repeated_start_request;
    logic       start_request;
  } ics_ctrl_t;

  // Register port request.
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ics_bus_req_t;

  // Master sequencer states.
  typedef enum logic [5:0] {
    M_IDLE   = 6'b000001,
    M_START  = 6'b000010,
    M_RSTART = 6'b000100,
    M_STOP   = 6'b001000,
    M_RECV   = 6'b010000,
    M_ACK    = 6'b100000
  } ics_mst_t;

  // Slave engine states.
  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_ADDR  = 6'b000010,
    S_ACK   = 6'b000100,
    S_RX    = 6'b001000,
    S_TX    = 6'b010000,
    S_TXACK = 6'b100000
  } ics_slv_t;

endpackage

/* core/ics_addr_match.sv */
// Slave address decision for one received address byte.
`timescale 1ns/100ps
module ics_addr_match
  import ics_pkg::*;
(
  // Received byte and context.
  input  wire logic [7:0] rx_byte,
  input  wire logic       ten_hi_seen,
  input  wire logic [9:0] own_addr,
  // Configuration.
  input  wire ics_ctrl_t  ctrl,
  // Decision.
  output logic            ack,
  output logic            gcall_hit,
  output logic            ten_hi_hit
);

  logic ten_hi_byte;

  // The upper byte of a ten-bit address carries the prefix and address bits 9:8.
  assign ten_hi_byte = (rx_byte[7:3] == ICS_TEN_PREFIX) && (rx_byte[2:1] == own_addr[9:8]);

  // Decide whether this byte is answered with an acknowledge.
  always_comb begin
    gcall_hit  = (rx_byte == ICS_GCALL_ADDR) && !ten_hi_seen;
    ten_hi_hit = ctrl.ten_bit_addr_select && !ten_hi_seen && ten_hi_byte;
    ack        = 1'b0;
    if (ctrl.accept_all_addresses) begin
      ack = 1'b1;
    end else if (gcall_hit) begin
      ack = ctrl.general_call_enable;
    end else if (ctrl.ten_bit_addr_select) begin
      ack = ten_hi_seen ? (rx_byte == own_addr[7:0]) : ten_hi_byte;
    end else begin
      ack = (rx_byte[7:1] == own_addr[6:0]);
    end
  end

endmodule

/* test/ics_bus_model.sv */
// Far side of the serial bus: pull-ups, an outside master and a data observer.
`timescale 1ns/100ps
module ics_bus_model (
  // Pin pull-downs from the block.
  input  wire logic sda_oe,
  input  wire logic scl_oe,
  // Resolved bus levels.
  output logic      sda,
  output logic      scl
);
  logic m_sda    = 1'b1;
  logic m_scl    = 1'b1;
  logic sda_seen = 1'b1;
  // Open drain with pull-ups, so a released line reads high.
  assign sda = m_sda & ~sda_oe;
  assign scl = m_scl & ~scl_oe;
  // Data level at every clock rise, used to judge the acknowledge slot.
  always @(posedge scl) sda_seen <= sda;
  // Start, n bytes from the top of w with an acknowledge slot each, Stop; a held clock is waited out.
  task automatic send_addr(input logic [15:0] w, input int n, output logic ack);
    logic [8:0] s;
    m_sda = 1'b0;
    #200;
    m_scl = 1'b0;
    ack = 1'b0;
    for (int k = 0; k < n; k++) begin
      s = {w[15:8], 1'b1};
      w = w << 8;
      repeat (9) begin
        #100 m_sda = s[8];
        s = s << 1;
        #100 m_scl = 1'b1;
        wait (scl);
        #200 m_scl = 1'b0;
      end
      if (k == 0) ack = ~sda_seen;
    end
    #100 m_sda = 1'b0;
    #100 m_scl = 1'b1;
    #200 m_sda = 1'b1;
    #200;
  endtask
endmodule

/* test/testbench.sv */
// Self-checking bench for the control bit sequencer.
`timescale 1ns/100ps
module testbench;
  import ics_pkg::*;
  logic         clk_sys    = 1'b0;
  logic         reset      = 1'b1;
  ics_bus_req_t bus_req    = '0;
  logic [15:0]  bus_rdata;
  logic         sda, scl, sda_out, sda_oe, scl_out, scl_oe, irq, ack;
  logic [15:0]  d;
  int           mismatches = 0;
  int           n_checks   = 0;
  logic [15:0]  mreq [6]   = '{16'h1001, 16'h1008, 16'h1030, 16'h1010, 16'h1002, 16'h1004};
  logic [15:0]  sctl [7]   = '{16'h1000, 16'h1000, 16'h1800, 16'h1000, 16'h1080, 16'h1400, 16'h1400};
  logic [7:0]   sbyt [7]   = '{8'hAA, 8'hA8, 8'hA8, 8'h00, 8'h00, 8'hAA, 8'hF0};
  logic         sack [7]   = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  ics_sequencer #(.QUARTER(4)) i_ics_sequencer (.clk_sys(clk_sys), .reset(reset), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl),
    .scl_out(scl_out), .scl_oe(scl_oe), .irq(irq));
  ics_bus_model i_ics_bus_model (.sda_oe(sda_oe), .scl_oe(scl_oe), .sda(sda), .scl(scl));

  // System clock, 50 ns period.
  initial forever #25 clk_sys = ~clk_sys;

  // Compares one value and counts the outcome.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask
  // One-cycle register read; data are taken in the following cycle.
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 v = bus_rdata;
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end

  // Main sequence: reset, registers, master sequences, then slave addressing.
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    rd(ICS_OFS_CTRL, d);
    chk(d, ICS_CTRL_RST);
    rd(4'h2, d);
    chk(d, 16'h0000);
    wr(ICS_OFS_MASK, 16'h0004);
    foreach (mreq[i]) begin
      wr(ICS_OFS_CTRL, mreq[i]);
      d = 16'h001F;
      for (int n = 0; n < 200 && d[4:0] != 5'h00; n++) rd(ICS_OFS_CTRL, d);
      chk(d, 16'h1000 | (mreq[i] & 16'h0020));
      if (i == 0 || i == 5) chk({13'h0000, sda_out, sda_oe, scl_oe}, (i == 0) ? 16'h0003 : 16'h0000);
      if (mreq[i][4]) chk({15'h0000, i_ics_bus_model.sda_seen}, {15'h0000, mreq[i][5]});
      rd(ICS_OFS_STATUS, d);
      chk(d, 16'h0001);
      if (i == 1) rd(ICS_OFS_DATA, d);
      if (i == 1) chk(d, 16'h00FF);
      wr(ICS_OFS_STATUS, 16'h000F);
    end
    wr(ICS_OFS_OWNADR, 16'h0055);
    foreach (sctl[i]) begin
      wr(ICS_OFS_CTRL, sctl[i]);
      i_ics_bus_model.send_addr({sbyt[i], 8'h00}, 1, ack);
      chk({15'h0000, ack}, {15'h0000, sack[i]});
      rd(ICS_OFS_STATUS, d);
      chk(d & 16'h0004, {13'h0000, sack[i] && sbyt[i] == 8'h00, 2'b00});
      chk({15'h0000, irq}, {15'h0000, sack[i] && sbyt[i] == 8'h00});
      wr(ICS_OFS_STATUS, 16'h000F);
    end
    // Slave receive with stretching: the clock stays low until software releases it.
    wr(ICS_OFS_CTRL, 16'h1040);
    fork
      i_ics_bus_model.send_addr(16'hAA5A, 2, ack);
      begin
        wait (scl_oe);
        repeat (8) @(posedge clk_sys);
        rd(ICS_OFS_CTRL, d);
        chk(d, 16'h0040);
        chk({14'h0000, scl, scl_out}, 16'h0000);
        rd(ICS_OFS_DATA, d);
        chk(d, 16'h005A);
        wr(ICS_OFS_CTRL, 16'h1040);
      end
    join
    chk({15'h0000, ack}, 16'h0001);
    rd(ICS_OFS_STATUS, d);
    chk(d, 16'h000A);
    wr(ICS_OFS_STATUS, 16'h000F);
    chk({15'h0000, irq}, 16'h0000);
    tally_and_finish();
  end
endmodule
